/* verilog/elt_defs.vh */
// constants for the loopback and test-pattern control block
`ifndef ELT_DEFS_VH
`define ELT_DEFS_VH
`define ELT_MODE_GMII     3'h0
`define ELT_MODE_RGMII    3'h1
`define ELT_MODE_MII      3'h2
`define ELT_MODE_TBI      3'h3
`define ELT_MODE_RTBI     3'h4
`define ELT_PAT_LOW       2'h0
`define ELT_PAT_MIXED     2'h1
`define ELT_PAT_HIGH      2'h2
`define ELT_PAT_CUSTOM    2'h3
`define ELT_CLK_MHZ       20
`define ELT_SOP_MIN_NS    119
`define ELT_SOP_MAX_NS    121
`define ELT_EOP_MIN_NS    211
`define ELT_EOP_MAX_NS    216
// least time rounds up to whole clock cycles
`define ELT_SOP_CYC       ((`ELT_SOP_MIN_NS * `ELT_CLK_MHZ + 999) / 1000)
`define ELT_EOP_CYC       ((`ELT_EOP_MIN_NS * `ELT_CLK_MHZ + 999) / 1000)
`define ELT_COL_MAX_TXC   64
`define ELT_RST_CODE      10'h000
`endif

/* verilog/elt_sync.v */
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module elt_sync (
	input  wire clk,
	input  wire reset_n,
	input  wire d,
	output wire q
);
	reg meta_q;
	reg sync_q;
	// first flop is read only by the second
	always @(posedge clk) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
	assign q = sync_q;
endmodule // elt_sync

/* verilog/elt_delay.v */
// fixed-length delay line for a code word and its marker
`timescale 1ns/1ps
module elt_delay #(
	parameter WIDTH = 11,
	parameter DEPTH = 3
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage_q [0:DEPTH-1];
	integer i;
	// shift one stage per clock
	always @(posedge clk) begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			if (!reset_n)
				stage_q[i] <= {WIDTH{1'b0}};
			else if (i == 0)
				stage_q[i] <= din;
			else
				stage_q[i] <= stage_q[i-1];
		end
	end
	assign dout = stage_q[DEPTH-1];
endmodule // elt_delay

/* verilog/elt_loop_ctrl.v */
// loopback muxes, drive-out gating, collision test and jitter pattern source
// Function
// [RULE1] diag loop in gmii/rgmii/mii: rx decoder takes tx encoder codes
// [RULE2] diag loop keeps rate buffers in path; rx clock may differ
// [RULE3] diag loop in tbi/rtbi: parallel tx codes return to parallel rx
// [RULE4] tbi/rtbi diag loop: rx clocking comes from gtx clock
// [RULE5] diag loop: drive-out 0 floats serial tx, 1 sends too; clock toggles
// [RULE6] diag loop: col held low unless collision test is set
// [RULE7] terminal loop: cdr takes serial data from own tx driver
// [RULE8] terminal loop: drive-out 0 floats serial tx, 1 sends too
// [RULE9] remote loop: tx logic takes rx parallel data, rest runs normally
// [RULE10] software clears diag and terminal bits when using remote loop
// [RULE11] remote loop in tbi/rtbi only with rx locked to reference
// [RULE12] remote loop: drive-out 0 forces rx pins low, 1 outputs them
// [RULE13] pattern enable: encoder sends selected jitter pattern codes
// [RULE14] enable set: pattern starts at once, packet cut off
// [RULE15] enable cleared: pattern stops at once, packet resumes
// [RULE16] clock outputs switch source or squelch without glitches
// [RULE17] gmii: start code leaves 119..121 ns after tx_en sampled; code raises sop_mark 3 clocks (150 ns) after
// [RULE18] gmii: rx_dv drops 211..216 ns after end code arrives; code drops it 5 clocks (250 ns) after deser_eop sampled
// [RULE19] collision test: col within 64 tx clocks, drops one after
// [RULE20] nothing enabled: all muxes in pass-through
`timescale 1ns/1ps
`include "elt_defs.vh"
module elt_loop_ctrl #(
	parameter SOP_CYC = `ELT_SOP_CYC,
	parameter EOP_CYC = `ELT_EOP_CYC
) (
	input  wire       clk,
	input  wire       reset_n,
	input  wire [2:0] parallel_mode,
	input  wire       diag_loop_enable,
	input  wire       diag_loop_drive_out,
	input  wire       terminal_loop_enable,
	input  wire       terminal_loop_drive_out,
	input  wire       remote_loop_enable,
	input  wire       remote_loop_drive_out,
	input  wire       col_test,
	input  wire       pattern_gen_enable,
	input  wire [1:0] pattern_select,
	input  wire [9:0] custom_pattern,
	input  wire       link_clk,
	input  wire       tx_en,
	input  wire       tx_er,
	input  wire [7:0] txd,
	input  wire [9:0] tbi_tx_code,
	input  wire [9:0] enc_code,
	input  wire       enc_sop,
	input  wire [9:0] deser_code,
	input  wire       deser_eop,
	input  wire [9:0] ser_rx_code,
	input  wire       rx_dv_in,
	input  wire       rx_er_in,
	input  wire [7:0] rxd_in,
	input  wire       crs_in,
	input  wire       col_in,
	input  wire       ref_clk_en,
	input  wire       rec_clk_en,
	input  wire       clk_sel_rec,
	input  wire       clk_squelch,
	output reg  [9:0] dec_code,
	output reg  [9:0] tx_code,
	output reg        ser_tx_data_oe_n,
	output reg  [9:0] cdr_code,
	output reg        tx_en_out,
	output reg        tx_er_out,
	output reg  [7:0] txd_out,
	output reg        rx_dv,
	output reg        rx_er,
	output reg  [7:0] rxd,
	output reg        crs,
	output reg        col,
	output reg        rx_clk_from_gtx,
	output reg        rate_buf_bypass,
	output reg        gp_clk_out,
	output reg        sop_mark,
	output reg        eop_dv_drop
);
	wire tbi_mode = (parallel_mode == `ELT_MODE_TBI) || (parallel_mode == `ELT_MODE_RTBI);
	wire gmii_mode = (parallel_mode == `ELT_MODE_GMII);
	wire lclk_s;
	wire ref_s;
	wire rec_s;
	wire [10:0] sop_dly;
	wire [10:0] eop_dly;
	reg  lclk_q;
	reg  [6:0] col_cnt_q;
	reg  tx_en_q;
	reg  [9:0] pat_q;
	reg  [9:0] pat_d;
	reg  [3:0] pat_idx_q;
	reg  sel_q;
	reg  sq_q;
	reg  ref_seen_q;
	reg  rec_seen_q;
	reg  ref_en_q;
	reg  rec_en_q;
	reg  dv_q;
	wire lclk_rise;
	wire tx_en_s;

	// link clock and gp clock sources arrive from outside: synchronise
	elt_sync u_lclk (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (link_clk),
		.q       (lclk_s)
	);
	elt_sync u_ref (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (ref_clk_en),
		.q       (ref_s)
	);
	elt_sync u_rec (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (rec_clk_en),
		.q       (rec_s)
	);
	// tx_en toggles on the link clock: the collision and start logic read it synchronised
	elt_sync u_txen (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (tx_en),
		.q       (tx_en_s)
	);

	always @(posedge clk) begin
		if (!reset_n)
			lclk_q <= 1'b0;
		else
			lclk_q <= lclk_s;
	end
	assign lclk_rise = lclk_s & ~lclk_q;

	// jitter pattern generator: steps one code per clock
	always @* begin
		case (pattern_select)
		`ELT_PAT_LOW:    pat_d = pat_idx_q[0] ? 10'h3E0 : 10'h01F;
		`ELT_PAT_MIXED:  pat_d = pat_idx_q[0] ? 10'h383 : 10'h07C;
		`ELT_PAT_HIGH:   pat_d = 10'h155;
		`ELT_PAT_CUSTOM: pat_d = custom_pattern;
		default:         pat_d = 10'h155;
		endcase
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			pat_q <= `ELT_RST_CODE;
			pat_idx_q <= 4'h0;
		end else begin
			pat_q <= pat_d;
			pat_idx_q <= pat_idx_q + 4'h1;
		end
	end

	// encoder output: pattern replaces coding at once, no packet boundary wait
	always @(posedge clk) begin
		if (!reset_n)
			tx_code <= `ELT_RST_CODE;
		else if (pattern_gen_enable)
			tx_code <= pat_q; // [RULE13] [RULE14]
		else if (tbi_mode)
			tx_code <= tbi_tx_code;
		else
			tx_code <= enc_code; // [RULE15] [RULE20]
	end

	// receive decoder source and terminal loop into the cdr
	always @(posedge clk) begin
		if (!reset_n) begin
			dec_code <= `ELT_RST_CODE;
			cdr_code <= `ELT_RST_CODE;
			rx_clk_from_gtx <= 1'b0;
			rate_buf_bypass <= 1'b0;
		end else begin
			if (diag_loop_enable && tbi_mode)
				dec_code <= tbi_tx_code; // [RULE3]
			else if (diag_loop_enable)
				dec_code <= enc_code; // [RULE1]
			else
				dec_code <= deser_code; // [RULE20]
			cdr_code <= terminal_loop_enable ? tx_code : ser_rx_code; // [RULE7]
			rx_clk_from_gtx <= diag_loop_enable & tbi_mode; // [RULE4]
			rate_buf_bypass <= 1'b0; // [RULE2] [RULE9]
		end
	end

	// serial driver floats only in reset or in diag or terminal loop without drive-out
	always @(posedge clk) begin
		if (!reset_n)
			ser_tx_data_oe_n <= 1'b1;
		else if (diag_loop_enable && !diag_loop_drive_out)
			ser_tx_data_oe_n <= 1'b1; // [RULE5]
		else if (terminal_loop_enable && !terminal_loop_drive_out)
			ser_tx_data_oe_n <= 1'b1; // [RULE8]
		else
			ser_tx_data_oe_n <= 1'b0;
	end

	// collision test counter in link clock cycles
	always @(posedge clk) begin
		if (!reset_n) begin
			col_cnt_q <= 7'h00;
			tx_en_q <= 1'b0;
		end else if (lclk_rise) begin
			tx_en_q <= tx_en_s;
			if (!tx_en_s || !col_test)
				col_cnt_q <= 7'h00;
			else if (col_cnt_q < 7'h7F)
				col_cnt_q <= col_cnt_q + 7'h01;
		end
	end

	// transmit side: remote loop feeds rx parallel data back
	always @(posedge clk) begin
		if (!reset_n) begin
			tx_en_out <= 1'b0;
			tx_er_out <= 1'b0;
			txd_out <= 8'h00;
		end else if (remote_loop_enable) begin
			tx_en_out <= rx_dv_in; // [RULE9]
			tx_er_out <= rx_er_in;
			txd_out <= rxd_in;
		end else begin
			tx_en_out <= tx_en;
			tx_er_out <= tx_er;
			txd_out <= txd;
		end
	end

	// receive pins: forced low in remote loop without drive-out
	always @(posedge clk) begin
		if (!reset_n) begin
			rx_dv <= 1'b0;
			rx_er <= 1'b0;
			rxd <= 8'h00;
			crs <= 1'b0;
			col <= 1'b0;
		end else if (remote_loop_enable && !remote_loop_drive_out) begin
			rx_dv <= 1'b0; // [RULE12]
			rx_er <= 1'b0;
			rxd <= 8'h00;
			crs <= 1'b0;
			col <= 1'b0;
		end else begin
			rx_dv <= gmii_mode ? (rx_dv_in & ~eop_dly[10]) : rx_dv_in;
			rx_er <= rx_er_in;
			rxd <= rxd_in;
			crs <= crs_in;
			if (col_test)
				col <= tx_en_q && tx_en_s && (col_cnt_q != 7'h00); // [RULE19]
			else if (diag_loop_enable)
				col <= 1'b0; // [RULE6]
			else
				col <= col_in;
		end
	end

	// latency lines: sop marker and end-of-packet rx_dv drop
	// the second tx_en synchroniser flop and the sop_mark register already spend two of the start cycles
	elt_delay #(.WIDTH(11), .DEPTH(SOP_CYC - 2)) u_sop (
		.clk     (clk),
		.reset_n (reset_n),
		.din     ({tx_en_s & ~tx_en_q & gmii_mode, 10'h000}),
		.dout    (sop_dly)
	);
	elt_delay #(.WIDTH(11), .DEPTH(EOP_CYC)) u_eop (
		.clk     (clk),
		.reset_n (reset_n),
		.din     ({deser_eop & gmii_mode, deser_code}),
		.dout    (eop_dly)
	);

	always @(posedge clk) begin
		if (!reset_n) begin
			sop_mark <= 1'b0;
			eop_dv_drop <= 1'b0;
			dv_q <= 1'b0;
		end else begin
			sop_mark <= sop_dly[10] | (enc_sop & 1'b0); // [RULE17]
			eop_dv_drop <= eop_dly[10]; // [RULE18]
			dv_q <= rx_dv;
		end
	end

	// glitch-free clock switch: change source or squelch only while output low
	always @(posedge clk) begin
		if (!reset_n) begin
			sel_q <= 1'b0;
			sq_q <= 1'b1;
			ref_seen_q <= 1'b0;
			rec_seen_q <= 1'b0;
			ref_en_q <= 1'b0;
			rec_en_q <= 1'b0;
			gp_clk_out <= 1'b0;
		end else begin
			ref_en_q <= ref_s;
			rec_en_q <= rec_s;
			ref_seen_q <= ref_en_q;
			rec_seen_q <= rec_en_q;
			if (!gp_clk_out) begin
				sel_q <= clk_sel_rec; // [RULE16]
				sq_q <= clk_squelch;
			end
			gp_clk_out <= sq_q ? 1'b0 : (sel_q ? rec_en_q : ref_en_q); // [RULE16]
		end
	end
endmodule // elt_loop_ctrl

/* test/elt_chk_checker.sv */
// concurrent checks on the loop control ports
`timescale 1ns/1ps
`include "elt_defs.vh"
module elt_chk (
	input wire       clk,
	input wire       reset_n,
	input wire [2:0] parallel_mode,
	input wire       diag_loop_enable,
	input wire       diag_loop_drive_out,
	input wire       terminal_loop_enable,
	input wire       terminal_loop_drive_out,
	input wire       remote_loop_enable,
	input wire       remote_loop_drive_out,
	input wire       col_test,
	input wire       tx_en,
	input wire [9:0] enc_code,
	input wire [9:0] dec_code,
	input wire       ser_tx_data_oe_n,
	input wire [7:0] rxd,
	input wire       rx_dv,
	input wire       crs,
	input wire       col,
	input wire       rx_clk_from_gtx,
	input wire       sop_mark
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// two samples of a setting so the output register has caught up
	sequence s_dlb_gmii;
		(diag_loop_enable && parallel_mode == `ELT_MODE_GMII)[*2];
	endsequence
	sequence s_tx_start;
		$rose(tx_en) && parallel_mode == `ELT_MODE_GMII;
	endsequence
	property p_dlb_dec; s_dlb_gmii |-> dec_code == $past(enc_code); endproperty
	a_dlb_dec: assert property (p_dlb_dec) else $error("decoder source");
	property p_dlb_hiz; (diag_loop_enable && !diag_loop_drive_out)[*2] |-> ser_tx_data_oe_n; endproperty
	a_dlb_hiz: assert property (p_dlb_hiz) else $error("diag float");
	property p_dlb_drv; (diag_loop_enable && diag_loop_drive_out)[*2] |-> !ser_tx_data_oe_n; endproperty
	a_dlb_drv: assert property (p_dlb_drv) else $error("diag drive");
	property p_tlb_hiz; (terminal_loop_enable && !terminal_loop_drive_out)[*2] |-> ser_tx_data_oe_n; endproperty
	a_tlb_hiz: assert property (p_tlb_hiz) else $error("terminal float");
	property p_dlb_col; (diag_loop_enable && !col_test)[*5] |-> !col; endproperty
	a_dlb_col: assert property (p_dlb_col) else $error("col in diag");
	property p_rlb_low; (remote_loop_enable && !remote_loop_drive_out)[*2] |-> !(rxd || rx_dv || crs || col); endproperty
	a_rlb_low: assert property (p_rlb_low) else $error("remote outputs");
	property p_tbi_clk; (diag_loop_enable && parallel_mode >= `ELT_MODE_TBI)[*2] |-> rx_clk_from_gtx; endproperty
	a_tbi_clk: assert property (p_tbi_clk) else $error("rx clock source");
	property p_sop; s_tx_start |-> ##[4:5] sop_mark; endproperty
	a_sop: assert property (p_sop) else $error("start latency");
endmodule // elt_chk

/* test/elt_mac_model.sv */
// transmit-side parallel source with its own free-running clock
`timescale 1ns/1ps
module elt_mac_model (
	input  wire       frame_req,
	output reg        link_clk,
	output reg        tx_en,
	output reg  [7:0] txd
);
	// clock offset from the system clock so edges never coincide
	initial begin
		{link_clk, tx_en, txd} = 10'h000;
		#13;
		forever #200 link_clk = ~link_clk;
	end
	// bytes count up in a frame, idle data flips every cycle
	always @(posedge link_clk) begin
		tx_en <= frame_req;
		txd   <= frame_req ? txd + 8'h01 : ~txd;
	end
endmodule // elt_mac_model

/* test/tb_elt_loop_ctrl.sv */
// self-checking bench for the loop control block
`timescale 1ns/1ps
`include "elt_defs.vh"
module tb_elt_loop_ctrl;
	reg        clk = 1'b0, reset_n = 1'b0, frame_req = 1'b0, col_test = 1'b0, enc_sop = 1'b0, deser_eop = 1'b0;
	reg        diag_loop_enable, diag_loop_drive_out, terminal_loop_enable, terminal_loop_drive_out;
	reg        remote_loop_enable, remote_loop_drive_out, pattern_gen_enable, tx_er, rx_er_in, col_in;
	reg        rx_dv_in, crs_in, ref_clk_en = 1'b1, rec_clk_en = 1'b1, clk_sel_rec = 1'b0, clk_squelch = 1'b0;
	reg  [2:0] parallel_mode = 3'h0;
	reg  [1:0] pattern_select = 2'h0;
	reg  [7:0] rxd_in;
	reg  [9:0] custom_pattern = 10'h2D1, tbi_tx_code, enc_code, deser_code, ser_rx_code, a, b, c;
	wire       link_clk, tx_en, ser_tx_data_oe_n, tx_en_out, tx_er_out, rx_dv, rx_er, crs, col;
	wire       rx_clk_from_gtx, rate_buf_bypass, gp_clk_out, sop_mark, eop_dv_drop;
	wire [7:0] txd, txd_out, rxd;
	wire [9:0] dec_code, tx_code, cdr_code;
	int        fail_count = 0, checks_done = 0, cyc = 0, n, s;
	elt_loop_ctrl i_dut (.*);
	elt_mac_model i_mac (.*);
	initial forever #25 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop;
		end
	end
	task tick(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task chk(input [9:0] got, input [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task chk1(input got, input exp);
		chk({9'h000, got}, {9'h000, exp});
	endtask
	task set_data(input [9:0] v);
		{enc_code, deser_code, ser_rx_code, tbi_tx_code} = {v, ~v, v ^ 10'h155, v[4:0], v[9:5]};
		{rxd_in, rx_dv_in, crs_in, tx_er, rx_er_in, col_in} = {v[7:0], 2'h3, v[2:0]};
	endtask
	task loops(input [6:0] m);
		{diag_loop_enable, diag_loop_drive_out, terminal_loop_enable, terminal_loop_drive_out,
			remote_loop_enable, remote_loop_drive_out, pattern_gen_enable} = m;
	endtask
	task t_norm;
		set_data(10'h2A5);
		clk_squelch = 1'b1;
		tick(3);
		chk(dec_code, 10'h15A);
		chk(cdr_code, 10'h3F0);
		chk(tx_code, 10'h2A5);
		chk({2'h0, rxd}, 10'h0A5);
		chk1(ser_tx_data_oe_n, 1'b0);
		chk1(gp_clk_out, 1'b0);
		{clk_squelch, clk_sel_rec} = 2'h1;
	endtask
	task t_diag;
		loops(7'h40);
		set_data(10'h0F3);
		tick(3);
		chk(dec_code, 10'h0F3);
		chk1(gp_clk_out, 1'b1);
		chk1(ser_tx_data_oe_n, 1'b1);
		chk1(rate_buf_bypass, 1'b0);
		chk1(col, 1'b0);
		diag_loop_drive_out = 1'b1;
		parallel_mode = `ELT_MODE_TBI;
		tick(3);
		chk1(ser_tx_data_oe_n, 1'b0);
		chk(dec_code, 10'h267);
		chk1(rx_clk_from_gtx, 1'b1);
		parallel_mode = `ELT_MODE_GMII;
	endtask
	task t_term;
		loops(7'h10);
		set_data(10'h333);
		tick(3);
		chk(cdr_code, 10'h333);
		chk1(ser_tx_data_oe_n, 1'b1);
		terminal_loop_drive_out = 1'b1;
		tick(3);
		chk1(ser_tx_data_oe_n, 1'b0);
	endtask
	task t_rem;
		loops(7'h04);
		set_data(10'h05A);
		tick(3);
		chk({2'h0, txd_out}, 10'h05A);
		chk({rx_dv, crs, rxd}, 10'h000);
		remote_loop_drive_out = 1'b1;
		tick(3);
		chk({rx_dv, crs, rxd}, 10'h35A);
	endtask
	task t_pat;
		for (s = 0; s < 4; s++) begin
			loops(7'h00);
			tick(2);
			pattern_select = s[1:0];
			loops(7'h01);
			tick(2);
			a = tx_code;
			tick(1);
			b = (s == 0) ? 10'h01F : (s == 1) ? 10'h07C : (s == 2) ? 10'h155 : 10'h2D1;
			c = (s == 0) ? 10'h3E0 : (s == 1) ? 10'h383 : b;
			chk1((a === b && tx_code === c) || (a === c && tx_code === b), 1'b1);
		end
		loops(7'h00);
		tick(2);
		chk(tx_code, 10'h05A);
	endtask
	task t_col;
		loops(7'h40);
		col_test = 1'b1;
		frame_req = 1'b1;
		for (n = 0; n < 530 && col !== 1'b1; n++) tick(1);
		chk1(col, 1'b1);
		frame_req = 1'b0;
		for (n = 0; n < 20 && tx_en !== 1'b0; n++) tick(1);
		tick(8);
		chk1(col, 1'b0);
		col_test = 1'b0;
		frame_req = 1'b1;
		tick(40);
		chk1(col, 1'b0);
		frame_req = 1'b0;
		loops(7'h00);
		tick(20);
	endtask
	task t_lat;
		frame_req = 1'b1;
		for (n = 0; n < 20 && tx_en !== 1'b1; n++) tick(1);
		for (n = 0; n < 10 && sop_mark !== 1'b1; n++) tick(1);
		chk1(n >= 3 && n <= 4, 1'b1);
		frame_req = 1'b0;
		deser_eop = 1'b1;
		tick(1);
		deser_eop = 1'b0;
		for (n = 0; n < 10 && eop_dv_drop !== 1'b1; n++) tick(1);
		chk1(n >= 5 && n <= 6, 1'b1);
		chk1(rx_dv, 1'b0);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// reset for five cycles, then each scenario in turn
	initial begin
		loops(7'h00);
		set_data(10'h000);
		tick(5);
		reset_n = 1'b1;
		t_norm;
		t_diag;
		t_term;
		t_rem;
		t_pat;
		t_col;
		t_lat;
		report_and_stop;
	end
endmodule // tb_elt_loop_ctrl
bind elt_loop_ctrl elt_chk i_chk (.*);
